// ---- e1cl_defs.svh ----
`ifndef E1CL_DEFS_SVH
`define E1CL_DEFS_SVH

// register offsets on the plain register port
`define E1CL_ADDR_W             8
`define E1CL_OFS_CODING_LOOP    8'h14
`define E1CL_OFS_NFAS_TX        8'h15
`define E1CL_OFS_MF_DL_SEL      8'h16

// reset values and writable masks
`define E1CL_RST_CODING_LOOP    8'h00
`define E1CL_RST_NFAS_TX        8'h00
`define E1CL_RST_MF_DL_SEL      8'h00
`define E1CL_MASK_CODING_LOOP   8'hEF
`define E1CL_MASK_NFAS_TX       8'h3F
`define E1CL_MASK_MF_DL_SEL     8'h7F

// coding and loopback control fields
`define E1CL_BIT_RX_HDB3        7
`define E1CL_BIT_METALLIC_LOOP  6
`define E1CL_BIT_TX_HDB3        5
`define E1CL_BIT_DIGITAL_LOOP   3
`define E1CL_BIT_REMOTE_LOOP    2
`define E1CL_BIT_BACKPLANE_LOOP 1
`define E1CL_BIT_PAYLOAD_LOOP   0

// non-frame-alignment transmit fields
`define E1CL_BIT_TX_ALARM       5
`define E1CL_NU_MSB             4

// multiframe and data link select fields
`define E1CL_BIT_MF_SELECT      6
`define E1CL_BIT_NB_SOURCE      5
`define E1CL_SA_MSB             4
`define E1CL_SA4_ONLY           5'h10

// positions inside time slot zero (bit index 0 = bit position one)
`define E1CL_TS0_LAST_IDX       8'h07
`define E1CL_IDX_NFAS_ONE       8'h01
`define E1CL_IDX_ALARM          8'h02
`define E1CL_IDX_SA4            8'h03

// line code substitution window
`define E1CL_HDB3_WIN           4

`endif

// ---- e1cl_pkg.sv ----
package e1cl_pkg;

  typedef struct packed {
    logic pos;
    logic neg;
  } e1cl_line_t;

  // symbol codes held in the encoder window
  typedef enum logic [1:0] {
    E1CL_SYM_ZERO  = 2'h0,
    E1CL_SYM_MARK  = 2'h1,
    E1CL_SYM_BIPOL = 2'h2,
    E1CL_SYM_VIOL  = 2'h3
  } e1cl_sym_t;

  typedef struct packed {
    e1cl_sym_t [3:0] win;
    logic            last_neg;
    logic            odd_marks;
    e1cl_line_t      line;
  } e1cl_enc_t;

  typedef struct packed {
    logic [3:0] win;
    logic       last_neg;
    logic       data;
  } e1cl_dec_t;

  typedef struct packed {
    logic [7:0] coding_loop;
    logic [7:0] nfas_tx;
    logic [7:0] mf_dl_sel;
    logic [7:0] rdata;
    logic       tx_bit;
    logic       rx_bit;
    logic       bp_out;
    e1cl_line_t tx_line;
    logic       mf_pulse;
    logic       dl_valid;
    logic       dl_data;
  } e1cl_core_t;

endpackage

// ---- e1cl_encoder.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "e1cl_defs.svh"

module e1cl_encoder
  import e1cl_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          bit_tick,
  input  wire logic          hdb3_en,
  input  wire logic          data_in,
  output e1cl_pkg::e1cl_line_t line_out
);
  import e1cl_pkg::*;

  e1cl_enc_t s_q;
  e1cl_enc_t s_d;
  e1cl_sym_t oldest;
  logic      odd_now;

  always_comb begin
    s_d     = s_q;
    oldest  = s_q.win[3];
    odd_now = s_q.odd_marks;
    if (bit_tick) begin
      // every mode sees the same four-bit latency so loop timing never shifts
      case (oldest)
        E1CL_SYM_MARK, E1CL_SYM_BIPOL: begin
          s_d.last_neg = ~s_q.last_neg;
          s_d.line     = s_q.last_neg ? e1cl_line_t'{pos: 1'b1, neg: 1'b0} : e1cl_line_t'{pos: 1'b0, neg: 1'b1};
          odd_now      = ~s_q.odd_marks;
        end
        E1CL_SYM_VIOL: begin
          s_d.line = s_q.last_neg ? e1cl_line_t'{pos: 1'b0, neg: 1'b1} : e1cl_line_t'{pos: 1'b1, neg: 1'b0};
          odd_now  = 1'b0;
        end
        default: begin
          s_d.line = '{pos: 1'b0, neg: 1'b0};
        end
      endcase
      s_d.odd_marks = odd_now;
      s_d.win[3:1] = s_q.win[2:0];
      s_d.win[0]   = data_in ? E1CL_SYM_MARK : E1CL_SYM_ZERO;
      // four zeros: B00V keeps violations alternating, 000V when marks since last V are odd
      if (hdb3_en && !data_in && s_q.win[2:0] == {3{E1CL_SYM_ZERO}}) begin
        s_d.win[3] = odd_now ? E1CL_SYM_ZERO : E1CL_SYM_BIPOL;
        s_d.win[0] = E1CL_SYM_VIOL;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign line_out = s_q.line;

endmodule
`default_nettype wire

// ---- e1cl_decoder.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "e1cl_defs.svh"

module e1cl_decoder
  import e1cl_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             bit_tick,
  input  wire logic             hdb3_en,
  input  wire e1cl_pkg::e1cl_line_t line_in,
  output logic                  data_out
);
  import e1cl_pkg::*;

  e1cl_dec_t s_q;
  e1cl_dec_t s_d;
  logic      pulse;
  logic      viol;

  always_comb begin
    s_d   = s_q;
    pulse = line_in.pos | line_in.neg;
    // a pulse of the same polarity as the previous one is a violation
    viol  = pulse && (line_in.neg == s_q.last_neg);
    if (bit_tick) begin
      s_d.data = s_q.win[3];
      s_d.win  = {s_q.win[2:0], pulse};
      if (pulse) begin
        s_d.last_neg = line_in.neg;
      end
      // undo a B00V or 000V word; with AMI every pulse is a one
      if (hdb3_en && viol) begin
        s_d.win = 4'h0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign data_out = s_q.data;

endmodule
`default_nettype wire

// ---- e1cl_core.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "e1cl_defs.svh"

module e1cl_core
  import e1cl_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic [`E1CL_ADDR_W-1:0]  reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  input  wire logic                      line_bit_tick,
  input  wire e1cl_pkg::e1cl_line_t      rx_line,
  output e1cl_pkg::e1cl_line_t           tx_line,
  input  wire logic                      backplane_serial_in,
  output logic                           backplane_serial_out,
  input  wire logic [7:0]                tx_bit_index,
  input  wire logic                      tx_nfas_frame,
  input  wire logic [7:0]                rx_bit_index,
  input  wire logic                      rx_nfas_frame,
  input  wire logic                      auto_remote_alarm_setting,
  input  wire logic                      auto_remote_alarm_in,
  input  wire logic                      tx_transparent_mode,
  input  wire logic [4:0]                national_buffer_bits,
  input  wire logic                      dl_tx_data,
  output logic                           dl_tx_take,
  output logic                           dl_rx_data,
  output logic                           dl_rx_valid,
  input  wire logic                      rx_sig_multiframe,
  input  wire logic                      rx_crc_multiframe,
  output logic                           rx_multiframe_pulse
);
  import e1cl_pkg::*;

  // bit 3 flags an Sa position, bits 2:0 give the matching register bit
  function automatic logic [3:0] sa_decode(input logic [7:0] idx);
    logic [3:0] r;
    r = 4'h0;
    if (idx >= `E1CL_IDX_SA4 && idx <= `E1CL_TS0_LAST_IDX) begin
      r = {1'b1, 3'(`E1CL_TS0_LAST_IDX - idx)};
    end
    return r;
  endfunction

  e1cl_core_t s_q;
  e1cl_core_t s_d;

  logic       rx_line_code_select;
  logic       metallic_loop_enable;
  logic       tx_line_code_select;
  logic       digital_loop_enable;
  logic       remote_loop_enable;
  logic       backplane_loop_enable;
  logic       payload_loop_enable;
  logic       tx_remote_alarm_bit;
  logic [4:0] tx_national_use_bits;
  logic       rx_multiframe_pulse_select;
  logic       national_buffer_source_select;
  logic [4:0] sa_datalink_select;
  logic [4:0] sa_sel_eff;
  logic [3:0] tx_sa;
  logic [3:0] rx_sa;
  logic       tx_in_ts0;
  logic       rx_in_ts0;
  logic       tx_insert;
  logic       tx_next;
  logic       rx_now;
  logic       dec_bit;
  e1cl_line_t enc_line;
  e1cl_line_t rx_analog;

  assign rx_line_code_select           = s_q.coding_loop[`E1CL_BIT_RX_HDB3];
  assign metallic_loop_enable          = s_q.coding_loop[`E1CL_BIT_METALLIC_LOOP];
  assign tx_line_code_select           = s_q.coding_loop[`E1CL_BIT_TX_HDB3];
  assign digital_loop_enable           = s_q.coding_loop[`E1CL_BIT_DIGITAL_LOOP];
  assign remote_loop_enable            = s_q.coding_loop[`E1CL_BIT_REMOTE_LOOP];
  assign backplane_loop_enable         = s_q.coding_loop[`E1CL_BIT_BACKPLANE_LOOP];
  assign payload_loop_enable           = s_q.coding_loop[`E1CL_BIT_PAYLOAD_LOOP];
  assign tx_remote_alarm_bit           = s_q.nfas_tx[`E1CL_BIT_TX_ALARM];
  assign tx_national_use_bits          = s_q.nfas_tx[`E1CL_NU_MSB:0];
  assign rx_multiframe_pulse_select    = s_q.mf_dl_sel[`E1CL_BIT_MF_SELECT];
  assign national_buffer_source_select = s_q.mf_dl_sel[`E1CL_BIT_NB_SOURCE];
  assign sa_datalink_select            = s_q.mf_dl_sel[`E1CL_SA_MSB:0];

  // transparent mode forces the receive data link onto Sa4 only; transmit then takes no data link bits
  assign sa_sel_eff = tx_transparent_mode ? `E1CL_SA4_ONLY : sa_datalink_select;

  assign tx_sa     = sa_decode(tx_bit_index);
  assign rx_sa     = sa_decode(rx_bit_index);
  assign tx_in_ts0 = tx_bit_index <= `E1CL_TS0_LAST_IDX;
  assign rx_in_ts0 = rx_bit_index <= `E1CL_TS0_LAST_IDX;
  assign tx_insert = !tx_transparent_mode && tx_nfas_frame && tx_in_ts0;

  // receiver input: own transmit pair replaces the external pair
  assign rx_analog = metallic_loop_enable ? s_q.tx_line : rx_line;

  // substitution for the receive line interface output
  assign rx_now = digital_loop_enable ? s_q.tx_bit : dec_bit;

  e1cl_encoder u_encoder (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .bit_tick (line_bit_tick),
    .hdb3_en  (tx_line_code_select),
    .data_in  (s_q.tx_bit),
    .line_out (enc_line)
  );

  e1cl_decoder u_decoder (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .bit_tick (line_bit_tick),
    .hdb3_en  (rx_line_code_select),
    .line_in  (rx_analog),
    .data_out (dec_bit)
  );

  // transmit bit selection for the current slot position
  always_comb begin
    tx_next    = backplane_serial_in;
    dl_tx_take = 1'b0;
    if (payload_loop_enable && !tx_in_ts0) begin
      tx_next = s_q.rx_bit;
    end
    if (tx_insert) begin
      case (tx_bit_index)
        `E1CL_IDX_NFAS_ONE: begin
          tx_next = 1'b1;
        end
        `E1CL_IDX_ALARM: begin
          // with the setting clear the alarm follows the receive side instead
          tx_next = auto_remote_alarm_setting ? tx_remote_alarm_bit : auto_remote_alarm_in;
        end
        default: begin
          if (tx_sa[3]) begin
            if (sa_sel_eff[tx_sa[2:0]]) begin
              tx_next    = dl_tx_data;
              dl_tx_take = line_bit_tick;
            end else if (national_buffer_source_select) begin
              tx_next = national_buffer_bits[tx_sa[2:0]];
            end else begin
              tx_next = tx_national_use_bits[tx_sa[2:0]];
            end
          end
        end
      endcase
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.rdata    = 8'h00;
    s_d.dl_valid = 1'b0;
    s_d.mf_pulse = rx_multiframe_pulse_select ? rx_crc_multiframe : rx_sig_multiframe;
    if (reg_wr) begin
      case (reg_addr)
        `E1CL_OFS_CODING_LOOP: begin
          s_d.coding_loop = reg_wdata & `E1CL_MASK_CODING_LOOP;
        end
        `E1CL_OFS_NFAS_TX: begin
          s_d.nfas_tx = reg_wdata & `E1CL_MASK_NFAS_TX;
        end
        `E1CL_OFS_MF_DL_SEL: begin
          s_d.mf_dl_sel = reg_wdata & `E1CL_MASK_MF_DL_SEL;
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `E1CL_OFS_CODING_LOOP: s_d.rdata = s_q.coding_loop;
        `E1CL_OFS_NFAS_TX:     s_d.rdata = s_q.nfas_tx;
        `E1CL_OFS_MF_DL_SEL:   s_d.rdata = s_q.mf_dl_sel;
        default:               s_d.rdata = 8'h00;
      endcase
    end
    if (line_bit_tick) begin
      s_d.tx_bit = tx_next;
      s_d.rx_bit = rx_now;
      // backplane output: echo of the input, or the receive stream
      s_d.bp_out = backplane_loop_enable ? backplane_serial_in : rx_now;
      // line pulses bypass the coder so violations go back untouched
      s_d.tx_line = remote_loop_enable ? rx_line : enc_line;
      if (rx_nfas_frame && rx_in_ts0 && rx_sa[3] && sa_sel_eff[rx_sa[2:0]]) begin
        s_d.dl_data  = rx_now;
        s_d.dl_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q             <= '0;
      s_q.coding_loop <= `E1CL_RST_CODING_LOOP;
      s_q.nfas_tx     <= `E1CL_RST_NFAS_TX;
      s_q.mf_dl_sel   <= `E1CL_RST_MF_DL_SEL;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata            = s_q.rdata;
  assign tx_line              = s_q.tx_line;
  assign backplane_serial_out = s_q.bp_out;
  assign dl_rx_data           = s_q.dl_data;
  assign dl_rx_valid          = s_q.dl_valid;
  assign rx_multiframe_pulse  = s_q.mf_pulse;

endmodule
`default_nettype wire

// ---- e1cl_core_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module e1cl_core_asserts
  import e1cl_pkg::*;
(
  input wire logic          ref_clk,
  input wire logic          rst_n,
  input wire logic [7:0]    reg_addr,
  input wire logic [7:0]    reg_wdata,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [7:0]    reg_rdata,
  input wire logic          line_bit_tick,
  input wire e1cl_pkg::e1cl_line_t rx_line,
  input wire e1cl_pkg::e1cl_line_t tx_line,
  input wire logic          backplane_serial_in,
  input wire logic          backplane_serial_out,
  input wire logic [7:0]    tx_bit_index,
  input wire logic          tx_nfas_frame,
  input wire logic [7:0]    rx_bit_index,
  input wire logic          rx_nfas_frame,
  input wire logic          tx_transparent_mode,
  input wire logic          dl_tx_take,
  input wire logic          dl_rx_valid,
  input wire logic          rx_sig_multiframe,
  input wire logic          rx_crc_multiframe,
  input wire logic          rx_multiframe_pulse
);
  logic [7:0] cl_q, nf_q, mf_q, rd_exp;
  logic       mf_crc, sa4_rx;
  assign mf_crc = mf_q[6];
  assign sa4_rx = mf_q[4] | tx_transparent_mode;
  // shadow of the three control registers, unused bits masked off
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cl_q <= 8'h00;
      nf_q <= 8'h00;
      mf_q <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 8'h14) cl_q <= reg_wdata & 8'hEF;
      if (reg_addr == 8'h15) nf_q <= reg_wdata & 8'h3F;
      if (reg_addr == 8'h16) mf_q <= reg_wdata & 8'h7F;
    end
  end
  always_comb begin
    case (reg_addr)
      8'h14: rd_exp = cl_q;
      8'h15: rd_exp = nf_q;
      8'h16: rd_exp = mf_q;
      default: rd_exp = 8'h00;
    endcase
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_rdata_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read");
  property p_readback; reg_rd |=> reg_rdata == $past(rd_exp); endproperty
  a_readback: assert property (p_readback) else $error("register read value wrong");
  property p_remote; line_bit_tick && cl_q[2] |=> tx_line == $past(rx_line); endproperty
  a_remote: assert property (p_remote) else $error("remote loop not followed");
  property p_bp_loop;
    line_bit_tick && cl_q[1] && !cl_q[3] |=> backplane_serial_out == $past(backplane_serial_in);
  endproperty
  a_bp_loop: assert property (p_bp_loop) else $error("backplane loop not followed");
  property p_mf_sel;
    $past(rst_n) |-> rx_multiframe_pulse == ($past(mf_crc) ? $past(rx_crc_multiframe) : $past(rx_sig_multiframe));
  endproperty
  a_mf_sel: assert property (p_mf_sel) else $error("multiframe pulse source wrong");
  property p_take_sa;
    line_bit_tick && tx_nfas_frame && !tx_transparent_mode && tx_bit_index inside {[8'h03:8'h07]}
      |-> dl_tx_take == mf_q[3'h7 - tx_bit_index[2:0]];
  endproperty
  a_take_sa: assert property (p_take_sa) else $error("data link take wrong");
  property p_take_off; !line_bit_tick || !tx_nfas_frame || tx_transparent_mode |-> !dl_tx_take; endproperty
  a_take_off: assert property (p_take_off) else $error("data link take outside slot");
  property p_rx_valid; line_bit_tick && rx_nfas_frame && rx_bit_index == 8'h03 |=> dl_rx_valid == $past(sa4_rx);
  endproperty
  a_rx_valid: assert property (p_rx_valid) else $error("sa4 receive valid wrong");
  c_remote: cover property (line_bit_tick && cl_q[2]);
  c_crc_mf: cover property (mf_crc && rx_crc_multiframe);
  c_take: cover property (dl_tx_take);
  c_rx_valid: cover property (dl_rx_valid);
endmodule

bind e1cl_core e1cl_core_asserts chk (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .line_bit_tick, .rx_line, .tx_line, .backplane_serial_in, .backplane_serial_out, .tx_bit_index, .tx_nfas_frame,
  .rx_bit_index, .rx_nfas_frame, .tx_transparent_mode, .dl_tx_take, .dl_rx_valid, .rx_sig_multiframe,
  .rx_crc_multiframe, .rx_multiframe_pulse);
`default_nettype wire

// ---- e1cl_line_partner.sv ----
`timescale 1ns/1ns
`default_nettype none
module e1cl_line_partner
  import e1cl_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  input  wire logic            mark,
  output logic                 tick,
  output logic                 tick_next,
  output e1cl_pkg::e1cl_line_t line
);
  logic [1:0] cnt_q;
  logic       last_neg_q;
  assign tick = cnt_q == 2'h3;
  assign tick_next = cnt_q == 2'h2;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
      last_neg_q <= 1'b0;
      line <= '0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      // ami: marks alternate polarity, a space sends no pulse
      if (tick) begin
        line.pos <= mark & last_neg_q;
        line.neg <= mark & ~last_neg_q;
        last_neg_q <= last_neg_q ^ mark;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test_e1_coding_loopback_nfas_control.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_e1_coding_loopback_nfas_control;
  import e1cl_pkg::*;
  logic       ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, mark = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, tx_bit_index = 8'h00, rx_bit_index = 8'h00, reg_rdata, rd;
  logic       backplane_serial_in = 1'b0, tx_nfas_frame = 1'b0, rx_nfas_frame = 1'b0, tx_transparent_mode = 1'b0;
  logic       auto_remote_alarm_setting = 1'b0, auto_remote_alarm_in = 1'b0, dl_tx_data = 1'b0;
  logic       rx_sig_multiframe = 1'b0, rx_crc_multiframe = 1'b0, bp_seen, take_seen, tx_exp;
  logic [4:0] national_buffer_bits = 5'h00, sa;
  logic       line_bit_tick, tick_next, backplane_serial_out, dl_tx_take, dl_rx_data, dl_rx_valid, rx_multiframe_pulse;
  e1cl_line_t rx_line, tx_line, rx_seen;
  int         n_errors = 0, samples_checked = 0;
  int         model [3] = '{0, 0, 0};
  int         mask [3] = '{8'hEF, 8'h3F, 8'h7F};

  always #5 ref_clk = ~ref_clk;

  e1cl_core uut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .line_bit_tick, .rx_line,
    .tx_line, .backplane_serial_in, .backplane_serial_out, .tx_bit_index, .tx_nfas_frame, .rx_bit_index,
    .rx_nfas_frame, .auto_remote_alarm_setting, .auto_remote_alarm_in, .tx_transparent_mode, .national_buffer_bits,
    .dl_tx_data, .dl_tx_take, .dl_rx_data, .dl_rx_valid, .rx_sig_multiframe, .rx_crc_multiframe, .rx_multiframe_pulse);
  e1cl_line_partner far_end (.ref_clk, .rst_n, .mark, .tick(line_bit_tick), .tick_next, .line(rx_line));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    if (a >= 8'h14 && a <= 8'h16) model[a - 8'h14] = d & mask[a - 8'h14];
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  function automatic logic [7:0] exp_rd(input int a);
    return (a >= 8'h14 && a <= 8'h16) ? model[a - 8'h14][7:0] : 8'h00;
  endfunction

  // drives one line bit period; captures what the tick edge will sample
  task automatic next_tick(input logic [7:0] idx, input logic nfas);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (!tick_next && n < 8);
    if (!tick_next) begin
      n_errors++;
      wrap_up();
    end
    @(posedge ref_clk);
    {mark, auto_remote_alarm_setting, auto_remote_alarm_in, dl_tx_data} <= 4'($urandom);
    // mostly zeros so the line coder meets runs of four
    backplane_serial_in <= &(2'($urandom));
    national_buffer_bits <= $urandom;
    tx_bit_index <= idx;
    rx_bit_index <= idx;
    tx_nfas_frame <= nfas;
    rx_nfas_frame <= nfas;
    #1;
    rx_seen = rx_line;
    bp_seen = backplane_serial_in;
    take_seen = dl_tx_take;
    @(posedge ref_clk);
    #1;
  endtask

  // end-to-end path: a bit taken at one tick must come out lat ticks later
  task automatic run_path(input logic [7:0] cfg, input int lat, input logic from_line);
    logic q[$];
    int   run;
    int   worst;
    run = 0;
    worst = 0;
    reg_write(8'h14, cfg);
    for (int k = 0; k < 64; k++) begin
      next_tick(8'h20, 1'b0);
      q.push_back(from_line ? mark : bp_seen);
      run = (tx_line == '0) ? run + 1 : 0;
      // first ticks flush the pipeline and let the receiver learn the pulse polarity
      if (k >= 24) begin
        worst = (run > worst) ? run : worst;
        check("loop path bit", from_line ? (tx_line.pos | tx_line.neg) : backplane_serial_out, q[k - lat]);
      end
    end
    if (cfg[6]) check("zero run above three", worst > 3, !cfg[5]);
    $display("path test %h done", cfg);
  endtask

  initial begin
    void'($urandom(32'hEC4A));
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int a = 8'h13; a <= 8'h17; a++) begin
      reg_read(a[7:0], rd);
      check("register reset value", rd, exp_rd(a));
      for (int k = 0; k < 2; k++) begin
        reg_write(a[7:0], k ? 8'($urandom) : 8'hFF);
        reg_read(a[7:0], rd);
        check("register readback", rd, exp_rd(a));
      end
    end
    $display("register test done");
    reg_write(8'h14, 8'h06);
    repeat (8) begin
      next_tick(8'h00, 1'b0);
      check("remote loop line", tx_line, rx_seen);
      check("backplane loop", backplane_serial_out, bp_seen);
    end
    $display("loopback test done");
    run_path(8'hE0, 12, 1'b0);
    run_path(8'h40, 12, 1'b0);
    run_path(8'h08, 1, 1'b0);
    run_path(8'h01, 13, 1'b1);
    for (int s = 0; s < 2; s++) begin
      reg_write(8'h16, s ? 8'h40 : 8'h00);
      repeat (6) begin
        @(posedge ref_clk);
        {rx_sig_multiframe, rx_crc_multiframe} <= $urandom;
        @(posedge ref_clk);
        #1;
        check("multiframe pulse", rx_multiframe_pulse, s ? rx_crc_multiframe : rx_sig_multiframe);
      end
    end
    $display("multiframe test done");
    reg_write(8'h14, 8'h08);
    reg_write(8'h15, 8'($urandom));
    for (int t = 0; t < 2; t++) begin
      sa = $urandom;
      @(posedge ref_clk);
      tx_transparent_mode <= t[0];
      reg_write(8'h16, {2'h0, 1'($urandom), sa});
      for (int i = 1; i < 9; i++) begin
        next_tick(i[7:0], 1'b1);
        // digital loop: the backplane output shows the bit sent one tick earlier
        if (i > 1) check("transmit slot bit", backplane_serial_out, tx_exp);
        if (dl_rx_valid) check("data link rx data", dl_rx_data, tx_exp);
        check("data link take", take_seen, !t && i > 2 && i < 8 && sa[7 - i]);
        check("data link rx valid", dl_rx_valid, t ? (i == 3) : (i > 2 && i < 8 && sa[7 - i]));
        tx_exp = backplane_serial_in;
        if (!t && i == 1) tx_exp = 1'b1;
        if (!t && i == 2) tx_exp = auto_remote_alarm_setting ? model[1][5] : auto_remote_alarm_in;
        if (!t && i > 2 && i < 8) begin
          tx_exp = model[2][5] ? national_buffer_bits[7 - i] : model[1][7 - i];
          if (sa[7 - i]) tx_exp = dl_tx_data;
        end
      end
    end
    $display("data link test done");
    wrap_up();
  end
endmodule
`default_nettype wire
